// ---- cmd_pkg.sv ----
// Constants of the serial command interpreter: characters, command codes, sizes.
// Assumes byte-wide receive and transmit strobes from a UART outside this block.
package cmd_pkg;
   localparam int LINE_MAX = 20;
   localparam logic [7:0] CH_CR = 8'h0d;
   localparam logic [7:0] CH_EQ = 8'h3d;
   localparam logic [7:0] CH_OK_O = 8'h4f;
   localparam logic [7:0] CH_OK_K = 8'h4b;
   localparam logic [7:0] CH_QM = 8'h3f;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam int ERR_DIGITS = 10;
   localparam int NSCALE_W = 3;
   localparam logic [2:0] TRUCK_MODE_MIN = 3'h1;
   localparam logic [2:0] TRUCK_MODE_MAX = 3'h6;
   // Command codes, also the key event code put out
   typedef enum logic [5:0] {
      C_NONE, C_ZERO, C_GROSSNET, C_GROSS, C_NET, C_TARE, C_UNITS, C_PRIM, C_SEC, C_TER,
      C_PRINT, C_ACCUM, C_SHOWTARE, C_CLR, C_CLRCN, C_CLRTAR, C_LEFT, C_RIGHT, C_UP, C_DOWN,
      C_SAVE, C_SAVEEXIT, C_CLRNV, C_DIGIT, C_DOT, C_ENTER, C_SOFT, C_LOCK, C_UNLOCK,
      C_TREG, C_WIN, C_WOUT, C_DEL, C_RPT_ALL, C_RPT_AUDIT, C_RPT_PROC, C_VERSION,
      C_HARDWARE, C_ERRQ, C_RESTART, C_RESTORE, C_PARAM
   } cmd_e;
   localparam int NKEYS = 32;
endpackage

// ---- cmd_line_buf.sv ----
// Line buffer: stores received characters until carriage return.
// Assumes one received byte per rx_valid_i pulse.
`timescale 1ns/1ps
module cmd_line_buf #(
   parameter int DEPTH = cmd_pkg::LINE_MAX
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Receive side
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   input wire logic consume_i,
   // Line out
   output logic line_ready_o,
   output logic overflow_o,
   output logic [$clog2(DEPTH+1)-1:0] len_o,
   output logic [DEPTH*8-1:0] line_o
);
   typedef struct packed {
      logic ready;
      logic ovf;
      logic [$clog2(DEPTH+1)-1:0] len;
      logic [DEPTH*8-1:0] data;
   } buf_s;
   buf_s st_reg, st_next;

   always_comb begin
      st_next = st_reg;
      if (consume_i) begin
         st_next.ready = 1'b0;
         st_next.ovf = 1'b0;
         st_next.len = '0;
         st_next.data = '0;
      end else if (rx_valid_i && !st_reg.ready) begin
         if (rx_data_i == cmd_pkg::CH_CR) begin
            st_next.ready = 1'b1;
         end else if (st_reg.len == DEPTH[$bits(st_reg.len)-1:0]) begin
            st_next.ovf = 1'b1;
         end else begin
            st_next.data[st_reg.len*8 +: 8] = rx_data_i;
            st_next.len = st_reg.len + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign line_ready_o = st_reg.ready;
   assign overflow_o = st_reg.ovf;
   assign len_o = st_reg.len;
   assign line_o = st_reg.data;

   chk_cr_ends_line: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      rx_valid_i && !st_reg.ready && !consume_i && rx_data_i == cmd_pkg::CH_CR |=> line_ready_o)
      else $error("carriage return did not close the line");
endmodule

// ---- cmd_interp.sv ----
// Serial command interpreter: parses a line, issues a key or action pulse or sets a key lock, answers OK or ?? (error query: code digits, then OK).
// Assumes a byte UART outside; tx_ready_i accepts one byte per cycle when high.
`timescale 1ns/1ps
module cmd_interp #(
   parameter int LINE_MAX = cmd_pkg::LINE_MAX,
   parameter int NKEYS = cmd_pkg::NKEYS
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Serial byte port
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   input wire logic tx_ready_i,
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   // Device state
   input wire logic setup_mode_i,
   input wire logic [2:0] truck_mode_i,
   input wire logic truck_reg_shown_i,
   input wire logic report_busy_i,
   input wire logic [4*cmd_pkg::ERR_DIGITS-1:0] err_code_i,
   input wire logic [NKEYS-1:0] panel_keys_i,
   // Actions
   output logic key_valid_o,
   output cmd_pkg::cmd_e key_code_o,
   output logic [3:0] key_arg_o,
   output logic [NKEYS-1:0] panel_keys_o,
   output logic [NKEYS-1:0] key_locked_o,
   output logic restart_o,
   output logic restore_o,
   output logic cal_discard_o,
   output logic report_o,
   output logic param_o
);
   localparam int LW = $clog2(LINE_MAX+1);
   typedef enum logic [1:0] {S_IDLE, S_EXEC, S_TX} state_e;
   typedef struct packed {
      state_e st;
      logic consume;
      logic ok;
      logic [4:0] tx_idx;
      logic tx_valid;
      logic [7:0] tx_data;
      logic key_valid;
      cmd_pkg::cmd_e key_code;
      logic [3:0] key_arg;
      logic [NKEYS-1:0] panel_keys;
      logic [NKEYS-1:0] locked;
      logic restart;
      logic restore;
      logic cal_discard;
      logic report;
      logic param;
   } ctl_s;
   ctl_s r_reg, r_next;

   logic line_ready;
   logic overflow;
   logic [LW-1:0] len;
   logic [LINE_MAX*8-1:0] line;

   cmd_line_buf #(.DEPTH(LINE_MAX)) u_buf (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .rx_valid_i(rx_valid_i),
      .rx_data_i(rx_data_i),
      .consume_i(r_reg.consume),
      .line_ready_o(line_ready),
      .overflow_o(overflow),
      .len_o(len),
      .line_o(line)
   );

   // Character at position
   function automatic logic [7:0] ch(input logic [LINE_MAX*8-1:0] l, input int i);
      ch = l[i*8 +: 8];
   endfunction

   // Compare a text (up to 20 chars, first char in high byte) against a span of the line
   function automatic logic match(input logic [LINE_MAX*8-1:0] l, input int off, input int n,
                                  input logic [LINE_MAX*8-1:0] s);
      logic m;
      m = 1'b1;
      for (int i = 0; i < LINE_MAX; i++) begin
         if (i < n && off + i < LINE_MAX && l[(off+i)*8 +: 8] != s[(n-1-i)*8 +: 8]) begin
            m = 1'b0;
         end
      end
      match = m;
   endfunction

   // Decode a key command name starting at off with length n
   function automatic cmd_pkg::cmd_e keyname(input logic [LINE_MAX*8-1:0] l, input int off,
                                             input int n);
      cmd_pkg::cmd_e c;
      c = cmd_pkg::C_NONE;
      if (n == 5 && match(l, off, 5, 40'h4b5a45524f)) c = cmd_pkg::C_ZERO;
      else if (n == 9 && match(l, off, 9, 72'h4b47524f53534e4554)) c = cmd_pkg::C_GROSSNET;
      else if (n == 6 && match(l, off, 6, 48'h4b47524f5353)) c = cmd_pkg::C_GROSS;
      else if (n == 4 && match(l, off, 4, 32'h4b4e4554)) c = cmd_pkg::C_NET;
      else if (n == 5 && match(l, off, 5, 40'h4b54415245)) c = cmd_pkg::C_TARE;
      else if (n == 6 && match(l, off, 6, 48'h4b554e495453)) c = cmd_pkg::C_UNITS;
      else if (n == 5 && match(l, off, 5, 40'h4b5052494d)) c = cmd_pkg::C_PRIM;
      else if (n == 4 && match(l, off, 4, 32'h4b534543)) c = cmd_pkg::C_SEC;
      else if (n == 4 && match(l, off, 4, 32'h4b544552)) c = cmd_pkg::C_TER;
      else if (n == 6 && match(l, off, 6, 48'h4b5052494e54)) c = cmd_pkg::C_PRINT;
      else if (n == 10 && match(l, off, 10, 80'h4b44495350414343554d)) c = cmd_pkg::C_ACCUM;
      else if (n == 9 && match(l, off, 9, 72'h4b4449535054415245)) c = cmd_pkg::C_SHOWTARE;
      else if (n == 4 && match(l, off, 4, 32'h4b434c52)) c = cmd_pkg::C_CLR;
      else if (n == 6 && match(l, off, 6, 48'h4b434c52434e)) c = cmd_pkg::C_CLRCN;
      else if (n == 7 && match(l, off, 7, 56'h4b434c52544152)) c = cmd_pkg::C_CLRTAR;
      else if (n == 5 && match(l, off, 5, 40'h4b4c454654)) c = cmd_pkg::C_LEFT;
      else if (n == 6 && match(l, off, 6, 48'h4b5249474854)) c = cmd_pkg::C_RIGHT;
      else if (n == 3 && match(l, off, 3, 24'h4b5550)) c = cmd_pkg::C_UP;
      else if (n == 5 && match(l, off, 5, 40'h4b444f574e)) c = cmd_pkg::C_DOWN;
      else if (n == 5 && match(l, off, 5, 40'h4b53415645)) c = cmd_pkg::C_SAVE;
      else if (n == 9 && match(l, off, 9, 72'h4b5341564545584954)) c = cmd_pkg::C_SAVEEXIT;
      else if (n == 6 && match(l, off, 6, 48'h4b434c524e56)) c = cmd_pkg::C_CLRNV;
      else if (n == 4 && match(l, off, 4, 32'h4b444f54)) c = cmd_pkg::C_DOT;
      else if (n == 6 && match(l, off, 6, 48'h4b454e544552)) c = cmd_pkg::C_ENTER;
      else if (n == 5 && match(l, off, 5, 40'h4b54524547)) c = cmd_pkg::C_TREG;
      else if (n == 4 && match(l, off, 4, 32'h4b57494e)) c = cmd_pkg::C_WIN;
      else if (n == 5 && match(l, off, 5, 40'h4b574f5554)) c = cmd_pkg::C_WOUT;
      else if (n == 4 && match(l, off, 4, 32'h4b44454c)) c = cmd_pkg::C_DEL;
      else if (n == 2 && ch(l, off) == "K" && ch(l, off + 1) >= "0" && ch(l, off + 1) <= "9")
         c = cmd_pkg::C_DIGIT;
      keyname = c;
   endfunction

   // Decoded line
   cmd_pkg::cmd_e cmd;
   cmd_pkg::cmd_e lock_target;
   logic [3:0] arg;
   logic has_eq;
   logic eq_ok;
   logic allowed;
   int eq_pos;

   always_comb begin
      cmd = cmd_pkg::C_NONE;
      arg = 4'h0;
      has_eq = 1'b0;
      eq_pos = 0;
      for (int i = LINE_MAX - 1; i >= 0; i--) begin
         if (i < int'(len) && ch(line, i) == cmd_pkg::CH_EQ) begin
            has_eq = 1'b1;
            eq_pos = i;
         end
      end
      // Assignment needs a name, a value and no spaces beside the equals sign
      eq_ok = has_eq && eq_pos > 0 && eq_pos < int'(len) - 1 &&
              ch(line, eq_pos - 1) != 8'h20 && ch(line, eq_pos + 1) != 8'h20;
      lock_target = keyname(line, eq_pos + 1, int'(len) - eq_pos - 1);
      if (!has_eq) begin
         cmd = keyname(line, 0, int'(len));
         if (cmd == cmd_pkg::C_DIGIT) arg = 4'(ch(line, 1) - cmd_pkg::CH_ZERO);
         if (len == 6 && match(line, 0, 5, 40'h4b534f4654) && ch(line, 5) >= "0" && ch(line, 5) <= "9") begin
            cmd = cmd_pkg::C_SOFT;
            arg = 4'(ch(line, 5) - cmd_pkg::CH_ZERO);
         end
         if (len == 7 && match(line, 0, 7, 56'h44554d50414c4c)) cmd = cmd_pkg::C_RPT_ALL;
         if (len == 9 && match(line, 0, 9, 72'h44554d504155444954)) cmd = cmd_pkg::C_RPT_AUDIT;
         if (len == 6 && match(line, 0, 6, 48'h535044554d50)) cmd = cmd_pkg::C_RPT_PROC;
         if (len == 7 && match(line, 0, 7, "VERSION")) cmd = cmd_pkg::C_VERSION;
         if (len == 8 && match(line, 0, 8, "HARDWARE")) cmd = cmd_pkg::C_HARDWARE;
         if (len == 2 && match(line, 0, 2, 16'h5845)) cmd = cmd_pkg::C_ERRQ;
         if (len == 2 && match(line, 0, 2, 16'h5253)) cmd = cmd_pkg::C_RESTART;
         if (len == 18 && match(line, 0, 18, 144'h5245534554434f4e46494755524154494f4e)) cmd = cmd_pkg::C_RESTORE;
      end else if (eq_pos == 5 && match(line, 0, 5, 40'h4b4c4f434b)) begin
         cmd = cmd_pkg::C_LOCK;
      end else if (eq_pos == 7 && match(line, 0, 7, 56'h4b554e4c4f434b)) begin
         cmd = cmd_pkg::C_UNLOCK;
      end else begin
         cmd = cmd_pkg::C_PARAM;
      end
      // Mode qualification
      case (cmd)
         cmd_pkg::C_NONE: allowed = 1'b0;
         cmd_pkg::C_ZERO, cmd_pkg::C_GROSSNET, cmd_pkg::C_PRINT,
         cmd_pkg::C_UNITS: allowed = !setup_mode_i;
         cmd_pkg::C_LEFT, cmd_pkg::C_RIGHT: allowed = setup_mode_i;
         cmd_pkg::C_SAVE, cmd_pkg::C_SAVEEXIT, cmd_pkg::C_CLRNV: allowed = setup_mode_i;
         cmd_pkg::C_LOCK, cmd_pkg::C_UNLOCK: allowed = eq_ok && lock_target != cmd_pkg::C_NONE &&
            lock_target != cmd_pkg::C_DIGIT && int'(lock_target) < NKEYS;
         cmd_pkg::C_WIN, cmd_pkg::C_WOUT: allowed = truck_mode_i >= cmd_pkg::TRUCK_MODE_MIN &&
                                                    truck_mode_i <= cmd_pkg::TRUCK_MODE_MAX;
         cmd_pkg::C_DEL: allowed = truck_reg_shown_i;
         cmd_pkg::C_RPT_ALL, cmd_pkg::C_RPT_AUDIT, cmd_pkg::C_RPT_PROC, cmd_pkg::C_VERSION,
         cmd_pkg::C_HARDWARE: allowed = !report_busy_i;
         cmd_pkg::C_RESTORE: allowed = setup_mode_i;
         cmd_pkg::C_PARAM: allowed = eq_ok;
         default: allowed = 1'b1;
      endcase
      if (overflow) allowed = 1'b0;
   end

   logic [4:0] msg_len;
   always_comb begin
      if (!r_reg.ok) msg_len = 5'd2;
      else if (r_reg.key_code == cmd_pkg::C_ERRQ) msg_len = 5'(cmd_pkg::ERR_DIGITS + 2);
      else msg_len = 5'd2;
   end

   always_comb begin
      r_next = r_reg;
      r_next.consume = 1'b0;
      r_next.key_valid = 1'b0;
      r_next.restart = 1'b0;
      r_next.restore = 1'b0;
      r_next.cal_discard = 1'b0;
      r_next.report = 1'b0;
      r_next.param = 1'b0;
      r_next.panel_keys = panel_keys_i & ~r_reg.locked;
      case (r_reg.st)
         S_IDLE: begin
            if (line_ready) begin
               r_next.st = S_EXEC;
               r_next.ok = allowed;
               r_next.key_code = cmd;
               r_next.key_arg = arg;
               r_next.consume = 1'b1;
            end
         end
         S_EXEC: begin
            if (r_reg.ok) begin
               case (r_reg.key_code)
                  cmd_pkg::C_LOCK: r_next.locked[lock_target[4:0]] = 1'b1;
                  cmd_pkg::C_UNLOCK: r_next.locked[lock_target[4:0]] = 1'b0;
                  cmd_pkg::C_RESTART: r_next.restart = 1'b1;
                  cmd_pkg::C_RESTORE: begin
                     r_next.restore = 1'b1;
                     r_next.cal_discard = 1'b1;
                  end
                  cmd_pkg::C_RPT_ALL, cmd_pkg::C_RPT_AUDIT, cmd_pkg::C_RPT_PROC,
                  cmd_pkg::C_VERSION, cmd_pkg::C_HARDWARE: r_next.report = 1'b1;
                  cmd_pkg::C_PARAM: r_next.param = 1'b1;
                  cmd_pkg::C_ERRQ: r_next.key_valid = 1'b0;
                  // Keys, pseudo keys, digits, tare: front-panel key event
                  default: r_next.key_valid = 1'b1;
               endcase
            end
            r_next.st = S_TX;
            r_next.tx_idx = 5'd0;
         end
         S_TX: begin
            if (!r_reg.tx_valid || tx_ready_i) begin
               if (r_reg.tx_idx == msg_len) begin
                  r_next.tx_valid = 1'b0;
                  r_next.st = S_IDLE;
               end else begin
                  r_next.tx_valid = 1'b1;
                  r_next.tx_idx = r_reg.tx_idx + 5'd1;
                  if (!r_reg.ok) r_next.tx_data = cmd_pkg::CH_QM;
                  else if (r_reg.tx_idx == msg_len - 5'd2) r_next.tx_data = cmd_pkg::CH_OK_O;
                  else if (r_reg.tx_idx == msg_len - 5'd1) r_next.tx_data = cmd_pkg::CH_OK_K;
                  else r_next.tx_data = cmd_pkg::CH_ZERO +
                     {4'h0, err_code_i[(cmd_pkg::ERR_DIGITS-1-int'(r_reg.tx_idx))*4 +: 4]};
               end
            end
         end
         default: r_next.st = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign tx_valid_o = r_reg.tx_valid;
   assign tx_data_o = r_reg.tx_data;
   assign key_valid_o = r_reg.key_valid;
   assign key_code_o = r_reg.key_code;
   assign key_arg_o = r_reg.key_arg;
   assign panel_keys_o = r_reg.panel_keys;
   assign key_locked_o = r_reg.locked;
   assign restart_o = r_reg.restart;
   assign restore_o = r_reg.restore;
   assign cal_discard_o = r_reg.cal_discard;
   assign report_o = r_reg.report;
   assign param_o = r_reg.param;

   chk_reject_qmark: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      tx_valid_o && !r_reg.ok |-> tx_data_o == cmd_pkg::CH_QM)
      else $error("rejection sent a wrong character");
   chk_ok_last: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      r_reg.st == S_TX && r_reg.ok && r_reg.tx_idx == msg_len && tx_valid_o |-> tx_data_o == cmd_pkg::CH_OK_K)
      else $error("acknowledgement did not end in K");
   chk_normal_only: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      r_reg.st == S_IDLE && line_ready && setup_mode_i && cmd == cmd_pkg::C_ZERO |=> !r_reg.ok)
      else $error("zero key taken in setup mode");
   chk_setup_save: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      r_reg.st == S_IDLE && line_ready && !setup_mode_i && cmd == cmd_pkg::C_SAVE |=> !r_reg.ok)
      else $error("save taken in normal mode");
   chk_truck_mode: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      r_reg.st == S_IDLE && line_ready && cmd == cmd_pkg::C_WIN && truck_mode_i == 3'h0 |=> !r_reg.ok)
      else $error("weigh-in taken outside truck mode");
   chk_delete_reg: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      r_reg.st == S_IDLE && line_ready && cmd == cmd_pkg::C_DEL && !truck_reg_shown_i |=> !r_reg.ok)
      else $error("delete taken without truck register");
   chk_restore_cal: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      restore_o |-> cal_discard_o && $past(r_reg.st) == S_EXEC)
      else $error("restore without calibration discard");
   chk_restore_setup: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      r_reg.st == S_IDLE && line_ready && cmd == cmd_pkg::C_RESTORE && !setup_mode_i ##1 1 |=> !restore_o)
      else $error("restore fired outside setup mode");
   chk_answer_follows: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      r_reg.st == S_IDLE && line_ready |-> ##[3:40] tx_valid_o)
      else $error("no answer after a line");
   chk_soft_index: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      r_reg.st == S_IDLE && line_ready && cmd == cmd_pkg::C_SOFT |=> key_arg_o == 4'(ch(line, 5) - 8'h30))
      else $error("softkey index not passed on");
   chk_errq_nokey: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      r_reg.st == S_EXEC && r_reg.key_code == cmd_pkg::C_ERRQ |=> !key_valid_o)
      else $error("error query raised a key event");
   cov_ok: cover property (@(posedge clk_i) disable iff (!rst_b_i) tx_valid_o && tx_data_o == cmd_pkg::CH_OK_K);
   cov_reject: cover property (@(posedge clk_i) disable iff (!rst_b_i) tx_valid_o && tx_data_o == cmd_pkg::CH_QM);
   cov_restore: cover property (@(posedge clk_i) disable iff (!rst_b_i) restore_o);
   cov_key: cover property (@(posedge clk_i) disable iff (!rst_b_i) key_valid_o && key_code_o == cmd_pkg::C_TARE);
endmodule

// ---- host_term.sv ----
// Host terminal model: sends command lines and collects the answer bytes.
// Assumes the interpreter's byte port; slow_i makes it stall the answer.
`timescale 1ns/1ps
module host_term (
   // Clock
   input wire logic clk_i,
   // Control
   input wire logic slow_i,
   // Byte port
   output logic rx_valid_o,
   output logic [7:0] rx_data_o,
   output logic tx_ready_o,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i
);
   logic [7:0] resp_q[$];
   logic [1:0] phase_reg;
   initial begin
      rx_valid_o = 1'b0;
      rx_data_o = 8'h00;
      tx_ready_o = 1'b1;
      phase_reg = 2'h0;
   end
   // Text sent as given, spaces beside the equals sign included, closed by carriage return
   task automatic send_line(input logic [159:0] c, input int n);
      for (int i = 0; i <= n; i++) begin
         @(posedge clk_i);
         rx_valid_o <= 1'b1;
         rx_data_o <= (i == n) ? cmd_pkg::CH_CR : c[(n-1-i)*8 +: 8];
      end
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_data_o <= ~cmd_pkg::CH_CR;
   endtask
   // Answer sink, ready one cycle in four when slow
   always @(posedge clk_i) begin
      phase_reg <= phase_reg + 2'h1;
      if (tx_valid_i && tx_ready_o) begin
         resp_q.push_back(tx_data_i);
      end
      tx_ready_o <= !slow_i || (phase_reg == 2'h3);
   end
endmodule

// ---- serial_command_interpreter_tb_top.sv ----
// Testbench of the serial command interpreter with a host terminal model.
// Assumes cmd_pkg, cmd_interp and host_term compiled before it.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module serial_command_interpreter_tb_top;
   logic clk_i = 1'b0;
   logic rst_b_i, slow, setup_mode, truck_reg_shown, report_busy;
   logic rx_valid, tx_ready, tx_valid, key_valid, restart, restore, cal_discard, report, param;
   logic [2:0] truck_mode;
   logic [39:0] err_code;
   logic [31:0] keys_in, keys_out, key_locked;
   logic [7:0] rx_data, tx_data;
   logic [3:0] key_arg, seen_arg;
   cmd_pkg::cmd_e key_code, seen_code;
   logic key_seen;
   logic clr_seen = 1'b0;
   logic [4:0] act_seen;
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;
   always #12.5 clk_i = ~clk_i;
   host_term host_u (.clk_i(clk_i), .slow_i(slow), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
      .tx_ready_o(tx_ready), .tx_valid_i(tx_valid), .tx_data_i(tx_data));
   cmd_interp dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
      .tx_ready_i(tx_ready), .tx_valid_o(tx_valid), .tx_data_o(tx_data), .setup_mode_i(setup_mode),
      .truck_mode_i(truck_mode), .truck_reg_shown_i(truck_reg_shown), .report_busy_i(report_busy),
      .err_code_i(err_code), .panel_keys_i(keys_in), .key_valid_o(key_valid), .key_code_o(key_code),
      .key_arg_o(key_arg), .panel_keys_o(keys_out), .key_locked_o(key_locked), .restart_o(restart),
      .restore_o(restore), .cal_discard_o(cal_discard), .report_o(report), .param_o(param));
   task automatic final_report;
      $display("Checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Event capture and hang limit
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (clr_seen) begin
         key_seen <= 1'b0;
         act_seen <= 5'h00;
      end else begin
         if (key_valid) begin
            key_seen <= 1'b1;
            seen_code <= key_code;
            seen_arg <= key_arg;
         end
         act_seen <= act_seen | {restart, restore, cal_discard, report, param};
      end
      if (cyc == 20000) begin
         err_total++;
         final_report();
      end
   end
   // One line out, answer bytes compared
   task automatic do_cmd(input logic [159:0] c, input int n, input logic [95:0] ex, input int ne);
      int w;
      @(negedge clk_i);
      clr_seen = 1'b1;
      host_u.resp_q.delete();
      @(negedge clk_i);
      clr_seen = 1'b0;
      host_u.send_line(c, n);
      w = 0;
      while (host_u.resp_q.size() < ne && w < 200) begin
         @(posedge clk_i);
         w++;
      end
      repeat (6) @(posedge clk_i);
      `CHK(host_u.resp_q.size(), ne)
      for (int i = 0; i < ne && i < host_u.resp_q.size(); i++) `CHK(host_u.resp_q[i], ex[(ne-1-i)*8 +: 8])
   endtask
   task automatic t_keys;
      do_cmd(40'h4b54415245, 5, 96'h4f4b, 2);
      `CHK(seen_code, cmd_pkg::C_TARE)
      for (int d = 0; d < 10; d++) begin
         do_cmd({8'h4b, 8'h30 + d[7:0]}, 2, 96'h4f4b, 2);
         `CHK(seen_code, cmd_pkg::C_DIGIT)
         `CHK(seen_arg, d[3:0])
      end
      do_cmd(48'h4b534f465433, 6, 96'h4f4b, 2);
      `CHK(seen_code, cmd_pkg::C_SOFT)
      `CHK(seen_arg, 4'h3)
      do_cmd(32'h4b464f4f, 4, 96'h3f3f, 2);
      `CHK(key_seen, 1'b0)
   endtask
   // Same command in setup then in normal mode
   task automatic mode_case(input logic [159:0] c, input int n, input logic oks, input logic okn,
      input cmd_pkg::cmd_e code);
      logic ok;
      for (int m = 0; m < 2; m++) begin
         ok = (m == 0) ? oks : okn;
         @(posedge clk_i);
         setup_mode <= (m == 0);
         do_cmd(c, n, ok ? 96'h4f4b : 96'h3f3f, 2);
         `CHK(key_seen, ok)
         if (key_seen === 1'b1) `CHK(seen_code, code)
      end
   endtask
   task automatic t_modes;
      mode_case(40'h4b5a45524f, 5, 1'b0, 1'b1, cmd_pkg::C_ZERO);
      mode_case(72'h4b47524f53534e4554, 9, 1'b0, 1'b1, cmd_pkg::C_GROSSNET);
      mode_case(48'h4b5052494e54, 6, 1'b0, 1'b1, cmd_pkg::C_PRINT);
      mode_case(48'h4b554e495453, 6, 1'b0, 1'b1, cmd_pkg::C_UNITS);
      mode_case(48'h4b47524f5353, 6, 1'b1, 1'b1, cmd_pkg::C_GROSS);
      mode_case(32'h4b544552, 4, 1'b1, 1'b1, cmd_pkg::C_TER);
      mode_case(40'h4b4c454654, 5, 1'b1, 1'b0, cmd_pkg::C_LEFT);
      mode_case(24'h4b5550, 3, 1'b1, 1'b1, cmd_pkg::C_UP);
      mode_case(40'h4b53415645, 5, 1'b1, 1'b0, cmd_pkg::C_SAVE);
      mode_case(48'h4b434c524e56, 6, 1'b1, 1'b0, cmd_pkg::C_CLRNV);
      mode_case(56'h4b434c52544152, 7, 1'b1, 1'b1, cmd_pkg::C_CLRTAR);
      mode_case(48'h4b434c52434e, 6, 1'b1, 1'b1, cmd_pkg::C_CLRCN);
   endtask
   task automatic t_truck;
      logic [2:0] tm;
      logic ok;
      for (int k = 0; k < 4; k++) begin
         tm = (k == 0) ? 3'h0 : (k == 1) ? 3'h1 : (k == 2) ? 3'h6 : 3'h7;
         ok = (tm >= 3'h1) && (tm <= 3'h6);
         @(posedge clk_i);
         truck_mode <= tm;
         do_cmd(32'h4b57494e, 4, ok ? 96'h4f4b : 96'h3f3f, 2);
         `CHK(key_seen, ok)
      end
      for (int s = 0; s < 2; s++) begin
         @(posedge clk_i);
         truck_reg_shown <= s[0];
         do_cmd(32'h4b44454c, 4, s[0] ? 96'h4f4b : 96'h3f3f, 2);
         `CHK(key_seen, s[0])
      end
   endtask
   task automatic t_lock;
      @(posedge clk_i);
      keys_in[cmd_pkg::C_ZERO] <= 1'b1;
      do_cmd(88'h4b4c4f434b3d4b5a45524f, 11, 96'h4f4b, 2);
      `CHK(key_locked[cmd_pkg::C_ZERO], 1'b1)
      `CHK(keys_out[cmd_pkg::C_ZERO], 1'b0)
      do_cmd(104'h4b554e4c4f434b3d4b5a45524f, 13, 96'h4f4b, 2);
      `CHK(key_locked[cmd_pkg::C_ZERO], 1'b0)
      `CHK(keys_out[cmd_pkg::C_ZERO], 1'b1)
   endtask
   task automatic t_reports;
      do_cmd(56'h44554d50414c4c, 7, 96'h4f4b, 2);
      `CHK(act_seen[1], 1'b1)
      @(posedge clk_i);
      report_busy <= 1'b1;
      do_cmd(56'h44554d50414c4c, 7, 96'h3f3f, 2);
      `CHK(act_seen[1], 1'b0)
      @(posedge clk_i);
      report_busy <= 1'b0;
      err_code <= 40'h0123456789;
      slow <= 1'b1;
      do_cmd(16'h5845, 2, 96'h303132333435363738394f4b, 12);
      `CHK(key_seen, 1'b0)
      @(posedge clk_i);
      slow <= 1'b0;
   endtask
   task automatic t_resets;
      do_cmd(16'h5253, 2, 96'h4f4b, 2);
      `CHK(act_seen[4], 1'b1)
      do_cmd(144'h5245534554434f4e46494755524154494f4e, 18, 96'h3f3f, 2);
      `CHK(act_seen[3:2], 2'b00)
      @(posedge clk_i);
      setup_mode <= 1'b1;
      do_cmd(144'h5245534554434f4e46494755524154494f4e, 18, 96'h4f4b, 2);
      `CHK(act_seen[3:2], 2'b11)
      do_cmd(48'h53432e413d35, 6, 96'h4f4b, 2);
      `CHK(act_seen[0], 1'b1)
      do_cmd(56'h53432e41203d35, 7, 96'h3f3f, 2);
      `CHK(act_seen[0], 1'b0)
   endtask
   initial begin
      rst_b_i = 1'b0;
      slow = 1'b0;
      setup_mode = 1'b0;
      truck_mode = 3'h0;
      truck_reg_shown = 1'b0;
      report_busy = 1'b0;
      err_code = 40'h0;
      keys_in = 32'h0;
      repeat (8) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      t_keys();
      t_modes();
      t_truck();
      t_lock();
      t_reports();
      t_resets();
      final_report();
   end
endmodule
